//--- inc/scc_pkg.sv
// constants, types and shared decode for the channel configuration bank
package scc_pkg;

  localparam int NUM_CH = 4;
  localparam int DW     = 32;
  localparam int AW     = 32;
  localparam int IW     = 20;
  localparam int CW     = 8;

  // register indices; byte address is four times the index
  localparam logic [IW-1:0] TX_IDX_BASE = 20'h30012;
  localparam logic [IW-1:0] RX_IDX_BASE = 20'h30013;
  localparam logic [IW-1:0] CH_STRIDE   = 20'h00010;
  localparam logic [IW-1:0] CTRL_IDX    = 20'h30001;
  localparam logic [IW-1:0] STAT_IDX    = 20'h30002;

  // transmit register fields
  localparam int TX_HALF_RATE_BIT  = 0;
  localparam int TX_PWRDN_BIT      = 1;
  localparam int TX_EMPH_LO_BIT    = 2;
  localparam int TX_EMPH_HI_BIT    = 3;
  localparam int TX_HALF_SWING_BIT = 4;
  localparam int TX_RSVD_LO_BIT    = 5;
  localparam int TX_RSVD_HI_BIT    = 6;
  localparam int TX_CODING_BIT     = 7;

  // receive register fields
  localparam int RX_HALF_RATE_BIT  = 0;
  localparam int RX_PWRDN_BIT      = 1;
  localparam int RX_RSVD_BIT       = 2;
  localparam int RX_CODING_BIT     = 3;
  localparam int RX_LINK_FSM_BIT   = 4;

  localparam logic [CW-1:0] TX_RESET   = 8'h00;
  localparam logic [CW-1:0] RX_RESET   = 8'h04;
  localparam logic [CW-1:0] RX_WR_MASK = 8'h1f;

  typedef enum logic [1:0] {
    EMPH_0    = 2'b00,
    EMPH_12P5 = 2'b01,
    EMPH_25   = 2'b10
  } scc_emph_t;

  typedef enum logic [0:0] {
    WB_IDLE = 1'b0,
    WB_ACK  = 1'b1
  } scc_wb_state_t;

  function automatic scc_emph_t emph_level(input logic lo, input logic hi);
    if (lo && hi) return EMPH_25;
    if (lo || hi) return EMPH_12P5;
    return EMPH_0;
  endfunction

  function automatic logic [IW-1:0] chan_idx(input logic [IW-1:0] base, input int ch);
    return base + CH_STRIDE * IW'(ch);
  endfunction

endpackage

//--- rtl/scc_wb_port.sv
// classic wishbone handshake with registered ack and read data
`timescale 1ns/1ps
`default_nettype none
module scc_wb_port (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [scc_pkg::DW-1:0] rd_data_i,
  output logic                       take_o,
  output logic [scc_pkg::DW-1:0]     wb_dat_o,
  output logic                       wb_ack_o
);
  import scc_pkg::*;

  typedef struct packed {
    scc_wb_state_t st;
    logic          ack;
    logic [DW-1:0] dat;
  } scc_wb_regs_t;

  scc_wb_regs_t q_r;
  scc_wb_regs_t q_nxt;

  always_comb begin
    q_nxt  = q_r;
    take_o = 1'b0;
    case (q_r.st)
      WB_IDLE: begin
        q_nxt.ack = 1'b0;
        if (wb_cyc_i && wb_stb_i) begin
          take_o    = 1'b1;
          q_nxt.st  = WB_ACK;
          q_nxt.ack = 1'b1;
          q_nxt.dat = wb_we_i ? '0 : rd_data_i;
        end
      end
      WB_ACK: begin
        // one idle cycle so a held strobe is not taken twice
        q_nxt.st  = WB_IDLE;
        q_nxt.ack = 1'b0;
      end
      default: begin
        q_nxt.st  = WB_IDLE;
        q_nxt.ack = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_r <= '{st: WB_IDLE, ack: 1'b0, dat: '0};
    end else begin
      q_r <= q_nxt;
    end
  end

  assign wb_ack_o = q_r.ack;
  assign wb_dat_o = q_r.dat;

endmodule // scc_wb_port
`default_nettype wire

//--- rtl/scc_chan_drive.sv
// registered per-channel control outputs toward the transceiver
`timescale 1ns/1ps
`default_nettype none
module scc_chan_drive (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic [scc_pkg::CW-1:0] tx_cfg_i,
  input  wire logic [scc_pkg::CW-1:0] rx_cfg_i,
  input  wire logic                  ten_gig_i,
  output logic                       tx_half_rate_o,
  output logic                       tx_power_down_o,
  output logic [1:0]                 tx_emph_level_o,
  output logic                       tx_half_swing_o,
  output logic                       tx_coding_enable_o,
  output logic                       rx_half_rate_sel_o,
  output logic                       rx_power_down_o,
  output logic                       rx_coding_enable_o,
  output logic                       rx_link_fsm_run_o
);
  import scc_pkg::*;

  typedef struct packed {
    logic      tx_hr;
    logic      tx_pd;
    scc_emph_t emph;
    logic      swing;
    logic      tx_code;
    logic      rx_hr;
    logic      rx_pd;
    logic      rx_code;
    logic      link;
  } scc_drv_regs_t;

  scc_drv_regs_t d_r;
  scc_drv_regs_t d_nxt;

  always_comb begin
    d_nxt         = d_r;
    d_nxt.tx_hr   = tx_cfg_i[TX_HALF_RATE_BIT];
    d_nxt.tx_pd   = tx_cfg_i[TX_PWRDN_BIT];
    d_nxt.emph    = emph_level(tx_cfg_i[TX_EMPH_LO_BIT],
                               tx_cfg_i[TX_EMPH_HI_BIT]);
    d_nxt.swing   = tx_cfg_i[TX_HALF_SWING_BIT];
    d_nxt.tx_code = tx_cfg_i[TX_CODING_BIT];
    d_nxt.rx_hr   = rx_cfg_i[RX_HALF_RATE_BIT];
    d_nxt.rx_pd   = rx_cfg_i[RX_PWRDN_BIT];
    d_nxt.rx_code = rx_cfg_i[RX_CODING_BIT];
    // ten gig attach mode overrides the enable
    d_nxt.link    = rx_cfg_i[RX_LINK_FSM_BIT] && !ten_gig_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      d_r <= '{emph: EMPH_0, default: 1'b0};
    end else begin
      d_r <= d_nxt;
    end
  end

  assign tx_half_rate_o     = d_r.tx_hr;
  assign tx_power_down_o    = d_r.tx_pd;
  assign tx_emph_level_o    = d_r.emph;
  assign tx_half_swing_o    = d_r.swing;
  assign tx_coding_enable_o = d_r.tx_code;
  assign rx_half_rate_sel_o = d_r.rx_hr;
  assign rx_power_down_o    = d_r.rx_pd;
  assign rx_coding_enable_o = d_r.rx_code;
  assign rx_link_fsm_run_o  = d_r.link;

endmodule // scc_chan_drive
`default_nettype wire

//--- rtl/scc_top.sv
// channel configuration register bank behind a classic wishbone slave
//
// The Wishbone register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - transmit power-down bit powers transmitter down, resets zero
// - emphasis bits: none 0%, one 12.5%, both 25%
// - half swing bit halves output swing, resets zero
// - transmit coding bit selects encoder, resets zero
// - receive coding bit selects decoder, resets zero
// - link fsm bit runs receive link machine
// - ten gig attach mode overrides link enable
// - transmit reserved bits reset zero and take whatever value a write stores
module scc_top (
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [scc_pkg::AW-1:0]       wb_adr_i,
  input  wire logic [3:0]                   wb_sel_i,
  input  wire logic [scc_pkg::DW-1:0]       wb_dat_i,
  output logic [scc_pkg::DW-1:0]            wb_dat_o,
  output logic                              wb_ack_o,
  output logic [scc_pkg::NUM_CH-1:0]        tx_half_rate_o,
  output logic [scc_pkg::NUM_CH-1:0]        tx_power_down_o,
  output logic [2*scc_pkg::NUM_CH-1:0]      tx_emph_level_o,
  output logic [scc_pkg::NUM_CH-1:0]        tx_half_swing_o,
  output logic [scc_pkg::NUM_CH-1:0]        tx_coding_enable_o,
  output logic [scc_pkg::NUM_CH-1:0]        rx_half_rate_sel_o,
  output logic [scc_pkg::NUM_CH-1:0]        rx_power_down_o,
  output logic [scc_pkg::NUM_CH-1:0]        rx_coding_enable_o,
  output logic [scc_pkg::NUM_CH-1:0]        rx_link_fsm_run_o,
  output logic [scc_pkg::NUM_CH-1:0]        ten_gig_attach_select_o
);
  import scc_pkg::*;

  typedef struct packed {
    logic [NUM_CH-1:0][CW-1:0] tx_cfg;
    logic [NUM_CH-1:0][CW-1:0] rx_cfg;
    logic [NUM_CH-1:0]         ten_gig;
  } scc_cfg_regs_t;

  localparam scc_cfg_regs_t S_RST = '{
    tx_cfg:  {NUM_CH{TX_RESET}},
    rx_cfg:  {NUM_CH{RX_RESET}},
    ten_gig: '0
  };

  scc_cfg_regs_t s_r;
  scc_cfg_regs_t s_nxt;

  logic          take;
  logic          adr_ok;
  logic [IW-1:0] idx;
  logic          wr;
  logic [DW-1:0] rd_data;

  // word index and upper-bit check for the decode
  assign idx    = wb_adr_i[IW+1:2];
  assign adr_ok = (wb_adr_i[AW-1:IW+2] == '0);
  // only byte lane 0 carries the eight configuration bits
  assign wr     = take && wb_we_i && wb_sel_i[0] && adr_ok;

  scc_wb_port u_wb (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .wb_cyc_i  (wb_cyc_i),
    .wb_stb_i  (wb_stb_i),
    .wb_we_i   (wb_we_i),
    .rd_data_i (rd_data),
    .take_o    (take),
    .wb_dat_o  (wb_dat_o),
    .wb_ack_o  (wb_ack_o)
  );

  // read mux; unmapped words read zero
  always_comb begin
    rd_data = '0;
    if (adr_ok) begin
      if (idx == CTRL_IDX) begin
        rd_data[NUM_CH-1:0] = s_r.ten_gig;
      end
      if (idx == STAT_IDX) begin
        rd_data[2*NUM_CH-1:0] = {tx_power_down_o, rx_link_fsm_run_o};
      end
      for (int ch = 0; ch < NUM_CH; ch++) begin
        if (idx == chan_idx(TX_IDX_BASE, ch)) begin
          rd_data[CW-1:0] = s_r.tx_cfg[ch];
        end
        if (idx == chan_idx(RX_IDX_BASE, ch)) begin
          rd_data[CW-1:0] = s_r.rx_cfg[ch];
        end
      end
    end
  end

  // register writes; bits hold until the next write or reset
  always_comb begin
    s_nxt = s_r;
    if (wr && idx == CTRL_IDX) begin
      s_nxt.ten_gig = wb_dat_i[NUM_CH-1:0];
    end
    for (int ch = 0; ch < NUM_CH; ch++) begin
      if (wr && idx == chan_idx(TX_IDX_BASE, ch)) begin
        s_nxt.tx_cfg[ch] = wb_dat_i[CW-1:0];
      end
      if (wr && idx == chan_idx(RX_IDX_BASE, ch)) begin
        // upper receive bits are unused and read zero
        s_nxt.rx_cfg[ch] = wb_dat_i[CW-1:0] & RX_WR_MASK;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // reserved receive bit comes up set
      s_r <= S_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ten_gig_attach_select_o <= '0;
    end else begin
      ten_gig_attach_select_o <= s_nxt.ten_gig;
    end
  end

  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    scc_chan_drive u_drv (
      .clk_i              (clk_i),
      .rst_i              (rst_i),
      .tx_cfg_i           (s_r.tx_cfg[g]),
      .rx_cfg_i           (s_r.rx_cfg[g]),
      .ten_gig_i          (s_r.ten_gig[g]),
      .tx_half_rate_o     (tx_half_rate_o[g]),
      .tx_power_down_o    (tx_power_down_o[g]),
      .tx_emph_level_o    (tx_emph_level_o[2*g+:2]),
      .tx_half_swing_o    (tx_half_swing_o[g]),
      .tx_coding_enable_o (tx_coding_enable_o[g]),
      .rx_half_rate_sel_o (rx_half_rate_sel_o[g]),
      .rx_power_down_o    (rx_power_down_o[g]),
      .rx_coding_enable_o (rx_coding_enable_o[g]),
      .rx_link_fsm_run_o  (rx_link_fsm_run_o[g])
    );
  end

  // helper vectors of the stored fields for the checks below
  logic [NUM_CH-1:0] pd_bits;
  logic [NUM_CH-1:0] swing_bits;
  logic [NUM_CH-1:0] txc_bits;
  logic [NUM_CH-1:0] rxc_bits;
  logic [NUM_CH-1:0] link_bits;
  logic [NUM_CH-1:0] rsvd_bits;

  always_comb begin
    for (int ch = 0; ch < NUM_CH; ch++) begin
      pd_bits[ch]    = s_r.tx_cfg[ch][TX_PWRDN_BIT];
      swing_bits[ch] = s_r.tx_cfg[ch][TX_HALF_SWING_BIT];
      txc_bits[ch]   = s_r.tx_cfg[ch][TX_CODING_BIT];
      rxc_bits[ch]   = s_r.rx_cfg[ch][RX_CODING_BIT];
      link_bits[ch]  = s_r.rx_cfg[ch][RX_LINK_FSM_BIT];
      rsvd_bits[ch]  = s_r.tx_cfg[ch][TX_RSVD_LO_BIT] | s_r.tx_cfg[ch][TX_RSVD_HI_BIT];
    end
  end

  logic hit_tx0;
  logic hit_rx0;
  assign hit_tx0 = adr_ok && idx == chan_idx(TX_IDX_BASE, 0);
  assign hit_rx0 = adr_ok && idx == chan_idx(RX_IDX_BASE, 0);

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_reset_values;
    $fell(rst_i) |-> (s_r.tx_cfg[0] == TX_RESET && s_r.rx_cfg[0] == RX_RESET
                      && tx_power_down_o == '0 && rx_link_fsm_run_o == '0);
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("configuration not at reset values after reset");

  property p_power_down;
    1'b1 |=> tx_power_down_o == $past(pd_bits);
  endproperty
  a_power_down: assert property (p_power_down)
    else $error("power down output does not follow its bit");

  property p_emph;
    1'b1 |=> tx_emph_level_o[1:0] ==
      ($past(s_r.tx_cfg[0][TX_EMPH_LO_BIT]) && $past(s_r.tx_cfg[0][TX_EMPH_HI_BIT]) ? 2'b10 :
       $past(s_r.tx_cfg[0][TX_EMPH_LO_BIT]) ^ $past(s_r.tx_cfg[0][TX_EMPH_HI_BIT]) ? 2'b01 :
       2'b00);
  endproperty
  a_emph: assert property (p_emph)
    else $error("emphasis level wrong for channel 0");

  property p_half_swing;
    1'b1 |=> tx_half_swing_o == $past(swing_bits);
  endproperty
  a_half_swing: assert property (p_half_swing)
    else $error("half swing output does not follow its bit");

  property p_tx_coding;
    1'b1 |=> tx_coding_enable_o == $past(txc_bits);
  endproperty
  a_tx_coding: assert property (p_tx_coding)
    else $error("transmit coding output does not follow its bit");

  property p_rx_coding;
    1'b1 |=> rx_coding_enable_o == $past(rxc_bits);
  endproperty
  a_rx_coding: assert property (p_rx_coding)
    else $error("receive coding output does not follow its bit");

  property p_link_run;
    1'b1 |=> rx_link_fsm_run_o == ($past(link_bits) & ~$past(s_r.ten_gig));
  endproperty
  a_link_run: assert property (p_link_run)
    else $error("link machine run state wrong");

  property p_ten_gig_override;
    s_r.ten_gig[0] |=> !rx_link_fsm_run_o[0];
  endproperty
  a_ten_gig_override: assert property (p_ten_gig_override)
    else $error("link machine runs in ten gig attach mode");

  property p_rsvd_zero;
    (rsvd_bits == '0) && !(take && wb_we_i) |=> rsvd_bits == '0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("transmit reserved bits changed without a write");

  property p_write_tx0;
    wr && hit_tx0 |=> wb_ack_o && s_r.tx_cfg[0] == $past(wb_dat_i[CW-1:0]);
  endproperty
  a_write_tx0: assert property (p_write_tx0)
    else $error("write to transmit register 0 not stored");

  property p_write_rx0;
    wr && hit_rx0 |=> s_r.rx_cfg[0] == ($past(wb_dat_i[CW-1:0]) & RX_WR_MASK);
  endproperty
  a_write_rx0: assert property (p_write_rx0)
    else $error("write to receive register 0 not stored");

  property p_hold;
    !(take && wb_we_i) |=> $stable(s_r);
  endproperty
  a_hold: assert property (p_hold)
    else $error("configuration changed without a write");

  property p_read_tx0;
    take && !wb_we_i && hit_tx0 |=> wb_ack_o && wb_dat_o == {24'h000000, $past(s_r.tx_cfg[0])};
  endproperty
  a_read_tx0: assert property (p_read_tx0)
    else $error("read of transmit register 0 returned wrong data");

  property p_ack_pulse;
    take |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack is not a single cycle pulse after a request");

  property p_read_rx0;
    take && !wb_we_i && hit_rx0 |=> wb_ack_o && wb_dat_o == {24'h000000, $past(s_r.rx_cfg[0])};
  endproperty
  a_read_rx0: assert property (p_read_rx0)
    else $error("read of receive register 0 returned wrong data");

  property p_unmapped_read;
    take && !wb_we_i && !adr_ok |=> wb_dat_o == '0;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("read outside the decoded range returned data");

  property p_lane_drop;
    take && wb_we_i && !wb_sel_i[0] |=> $stable(s_r);
  endproperty
  a_lane_drop: assert property (p_lane_drop)
    else $error("write without byte lane 0 changed a register");

  property p_ack_needs_take;
    !take |=> !wb_ack_o;
  endproperty
  a_ack_needs_take: assert property (p_ack_needs_take)
    else $error("ack given without a taken request");

  property p_attach_out;
    1'b1 |-> ten_gig_attach_select_o == s_r.ten_gig;
  endproperty
  a_attach_out: assert property (p_attach_out)
    else $error("attach select output differs from its register");

  property p_write_ctrl;
    wr && idx == CTRL_IDX |=> ten_gig_attach_select_o == $past(wb_dat_i[NUM_CH-1:0]);
  endproperty
  a_write_ctrl: assert property (p_write_ctrl)
    else $error("write to attach select register not stored");

  property p_rx_rsvd_reset;
    $fell(rst_i) |-> s_r.rx_cfg[NUM_CH-1][RX_RSVD_BIT] && tx_emph_level_o == '0;
  endproperty
  a_rx_rsvd_reset: assert property (p_rx_rsvd_reset)
    else $error("reserved receive bit or emphasis wrong after reset");

endmodule // scc_top
`default_nettype wire

//--- verification/scc_top_tb.sv
// self-checking bench for the channel configuration bank
`timescale 1ns/1ps
`default_nettype none
module scc_top_tb;
  import scc_pkg::*;
  logic                clk_i    = 1'b0;
  logic                rst_i    = 1'b1;
  logic                wb_cyc_i = 1'b0;
  logic                wb_stb_i = 1'b0;
  logic                wb_we_i  = 1'b0;
  logic [AW-1:0]       wb_adr_i = '0;
  logic [3:0]          wb_sel_i = 4'h0;
  logic [DW-1:0]       wb_dat_i = '0;
  logic [DW-1:0]       wb_dat_o;
  logic                wb_ack_o;
  logic [NUM_CH-1:0]   tx_hr, tx_pd, tx_hs, tx_ce, rx_hr, rx_pd, rx_ce, rx_run, tg;
  logic [2*NUM_CH-1:0] tx_em;
  logic [CW-1:0]       tx_m [NUM_CH];
  logic [CW-1:0]       rx_m [NUM_CH];
  logic [3:0]          ctrl_m;
  int                  n_mismatch = 0;
  int                  checks     = 0;
  int                  cyc_cnt    = 0;
  int                  seed       = 32'h9126de02;
  int                  k;
  int                  g;
  logic [3:0]          tg_pat [4] = '{4'hf, 4'h0, 4'ha, 4'h5};

  scc_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_half_rate_o(tx_hr),
    .tx_power_down_o(tx_pd), .tx_emph_level_o(tx_em), .tx_half_swing_o(tx_hs),
    .tx_coding_enable_o(tx_ce), .rx_half_rate_sel_o(rx_hr), .rx_power_down_o(rx_pd),
    .rx_coding_enable_o(rx_ce), .rx_link_fsm_run_o(rx_run), .ten_gig_attach_select_o(tg));

  always #2.5 clk_i = ~clk_i;

  function automatic logic [AW-1:0] adr_of(input logic [IW-1:0] base, input int ch);
    logic [IW-1:0] idx;
    idx = base + IW'(16 * ch);
    return {10'h000, idx, 2'b00};
  endfunction

  function automatic logic [1:0] emph_exp(input logic lo, input logic hi);
    return (lo & hi) ? 2'b10 : ((lo | hi) ? 2'b01 : 2'b00);
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // one classic cycle; held until ack is sampled high
  task automatic xfer(input logic we, input logic [AW-1:0] a, input logic [DW-1:0] d,
                      input logic [3:0] sel, output logic [DW-1:0] rd);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= sel;
    // a missing ack is ended by the bench timeout
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d, input logic [3:0] sel);
    logic [DW-1:0] r;
    xfer(1'b1, a, d, sel, r);
  endtask

  task automatic rd_chk(input logic [AW-1:0] a, input logic [DW-1:0] e);
    logic [DW-1:0] r;
    xfer(1'b0, a, $random(seed), 4'hf, r);
    check(r, e, "read data");
  endtask

  task automatic regs_chk();
    logic [3:0] run;
    logic [3:0] pd;
    for (int c = 0; c < NUM_CH; c++) begin
      run[c] = rx_m[c][RX_LINK_FSM_BIT] & ~ctrl_m[c];
      pd[c]  = tx_m[c][TX_PWRDN_BIT];
      rd_chk(adr_of(TX_IDX_BASE, c), {24'h0, tx_m[c]});
      rd_chk(adr_of(RX_IDX_BASE, c), {24'h0, rx_m[c]});
    end
    rd_chk({10'h000, CTRL_IDX, 2'b00}, {28'h0, ctrl_m});
    rd_chk({10'h000, STAT_IDX, 2'b00}, {24'h0, pd, run});
  endtask

  task automatic out_chk();
    @(negedge clk_i);
    for (int c = 0; c < NUM_CH; c++) begin
      check(tx_pd[c], tx_m[c][TX_PWRDN_BIT], "power down");
      check(tx_em[2*c+:2], emph_exp(tx_m[c][2], tx_m[c][3]), "emphasis");
      check(tx_hs[c], tx_m[c][TX_HALF_SWING_BIT], "half swing");
      check(tx_ce[c], tx_m[c][TX_CODING_BIT], "encoder");
      check(rx_ce[c], rx_m[c][RX_CODING_BIT], "decoder");
      check(rx_run[c], rx_m[c][RX_LINK_FSM_BIT] & ~ctrl_m[c], "link run");
      check(tg[c], ctrl_m[c], "attach select");
      check({tx_hr[c], rx_hr[c], rx_pd[c]}, {tx_m[c][0], rx_m[c][0], rx_m[c][1]}, "rate pd");
    end
  endtask

  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int c = 0; c < NUM_CH; c++) begin
      tx_m[c] = TX_RESET;
      rx_m[c] = RX_RESET;
    end
    ctrl_m = 4'h0;
  endtask

  // random write of one register; reserved bits kept as software must
  task automatic rand_wr(input int kind, input int ch);
    logic [DW-1:0] d;
    d = $random(seed);
    if (kind == 0) begin
      tx_m[ch] = d[7:0] & 8'h9f;
      wr(adr_of(TX_IDX_BASE, ch), {d[31:8], tx_m[ch]}, 4'h1);
    end else if (kind == 1) begin
      d[RX_RSVD_BIT] = 1'b1;
      rx_m[ch] = d[7:0] & RX_WR_MASK;
      wr(adr_of(RX_IDX_BASE, ch), d, 4'h1);
    end else begin
      ctrl_m = d[3:0];
      wr({10'h000, CTRL_IDX, 2'b00}, d, 4'h1);
    end
  endtask

  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  initial begin
    do_reset();
    out_chk();
    regs_chk();
    $display("test reset values done");
    for (int e = 0; e < 4; e++) begin
      for (int c = 0; c < NUM_CH; c++) begin
        tx_m[c] = (CW'($random(seed)) & 8'h93) | CW'(e << 2);
        wr(adr_of(TX_IDX_BASE, c), {24'h0, tx_m[c]}, 4'h1);
      end
      out_chk();
    end
    $display("test emphasis table done");
    repeat (40) begin
      k = {$random(seed)} % 3;
      g = {$random(seed)} % NUM_CH;
      rand_wr(k, g);
      rd_chk(k == 0 ? adr_of(TX_IDX_BASE, g) : adr_of(RX_IDX_BASE, g),
             {24'h0, k == 0 ? tx_m[g] : rx_m[g]});
      out_chk();
    end
    regs_chk();
    $display("test random traffic done");
    for (int c = 0; c < NUM_CH; c++) begin
      rx_m[c] = 8'h14;
      wr(adr_of(RX_IDX_BASE, c), 32'h14, 4'h1);
    end
    foreach (tg_pat[i]) begin
      ctrl_m = tg_pat[i];
      wr({10'h000, CTRL_IDX, 2'b00}, {28'h0, ctrl_m}, 4'h1);
      out_chk();
    end
    $display("test attach override done");
    wr(adr_of(TX_IDX_BASE, 0), 32'h0000_0082, 4'he);
    wr(32'h000c_0100, 32'hffff_ffff, 4'hf);
    rd_chk(32'h000c_0100, 32'h0);
    wr(adr_of(TX_IDX_BASE, 1) | 32'h0040_0000, 32'h0000_0082, 4'h1);
    rd_chk(adr_of(TX_IDX_BASE, 1) | 32'h0040_0000, 32'h0);
    wr({10'h000, STAT_IDX, 2'b00}, 32'hff, 4'h1);
    regs_chk();
    out_chk();
    $display("test refused writes done");
    rand_wr(0, 2);
    rand_wr(1, 3);
    do_reset();
    regs_chk();
    out_chk();
    $display("test second reset done");
    tally_and_finish();
  end
endmodule // scc_top_tb
`default_nettype wire
